//--- test/clk_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module clk_src_model (
    // Control from the bench
    input  wire logic        ext_en_n_i,
    // Clock pins toward the block
    output wire logic [11:0] pins_o
);
    logic [10:0] osc;

    // Free-running oscillators, pin k half period (k+2)*100 ns
    for (genvar k = 0; k < 11; k++) begin : g_osc
        initial begin
            osc[k] = 1'b0;
            forever #((k + 2) * 100) osc[k] = ~osc[k];
        end
    end

    // Enable pin is a plain level, unrelated in phase to the oscillators
    assign pins_o = {ext_en_n_i, osc};
endmodule : clk_src_model
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
    import clk_ctl_pkg::*;
;
    // Bench-driven inputs
    logic clk_i, srst_i, port_data_sel_i, port_wr_i, port_rd_i, ext_en_n;
    logic [7:0] port_wdata_i;
    logic hsync_i, vsync_i, csync_i, blank_i, sleep_i, standby_i;
    logic indep_refresh_i, panel_or_tv_i, seq_8dot_i, seq_dot_div2_i;
    logic [1:0] legacy_clk_sel_i;
    wire logic [NUM_SRC-1:0] clk_pins_i;
    // Observed outputs
    logic [7:0] port_rdata_o, mem_clock_numerator_o, vid_clock_numerator_o;
    logic [5:0] mem_clock_denominator_o, vid_clock_denominator_o;
    logic [1:0] vclk_trim_o, mclk_trim_o, post_scaler_o;
    logic video_clock_o, tv_clock_o, tv_clock_or_blank_o;
    logic panel_refresh_clock_o, crt_horiz_sync_pin_o, crt_vert_sync_o;
    logic char_8dot_o, dot_clock_div2_o, subcarrier_free_run_o;
    logic test_data_direct_o, panel_link_clock_o, dram_refresh_clock_o;
    int   n_errors = 0;
    int   cmp_count = 0;
    // Register table: index, reset value, readback after all ones
    logic [7:0] ri [7] = '{IDX_TV_SYNC, IDX_SEL_ONE, IDX_SEL_TWO,
        IDX_MEM_NUM, IDX_MEM_DEN, IDX_VID_NUM, IDX_VID_DEN};
    logic [7:0] rv [7] = '{RST_TV_SYNC, RST_SEL_ONE, RST_SEL_TWO,
        RST_MEM_NUM, RST_MEM_DEN, RST_VID_NUM, RST_VID_DEN};
    logic [7:0] rf [7] = '{8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
    wire logic [4:0] clks = {dram_refresh_clock_o, panel_link_clock_o,
        panel_refresh_clock_o, tv_clock_o, video_clock_o};

    display_clock_select_and_synth dut (
        .clk_i, .srst_i, .port_data_sel_i, .port_wr_i, .port_rd_i,
        .port_wdata_i, .port_rdata_o, .clk_pins_i, .hsync_i, .vsync_i,
        .csync_i, .blank_i, .sleep_i, .standby_i, .indep_refresh_i,
        .panel_or_tv_i, .legacy_clk_sel_i, .seq_8dot_i, .seq_dot_div2_i,
        .video_clock_o, .tv_clock_o, .tv_clock_or_blank_o,
        .panel_refresh_clock_o, .panel_link_clock_o,
        .dram_refresh_clock_o, .crt_horiz_sync_pin_o, .crt_vert_sync_o,
        .char_8dot_o, .dot_clock_div2_o, .subcarrier_free_run_o,
        .test_data_direct_o, .vclk_trim_o, .mclk_trim_o,
        .mem_clock_numerator_o, .mem_clock_denominator_o,
        .vid_clock_numerator_o, .vid_clock_denominator_o, .post_scaler_o
    );
    clk_src_model far (.ext_en_n_i(ext_en_n), .pins_o(clk_pins_i));

    // 20 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Index write, then data write on the next edge
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(negedge clk_i);
        port_data_sel_i = 1'b0;
        port_wr_i = 1'b1;
        port_wdata_i = idx;
        @(negedge clk_i);
        port_data_sel_i = 1'b1;
        port_wdata_i = d;
        @(negedge clk_i);
        port_wr_i = 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        @(negedge clk_i);
        port_data_sel_i = 1'b0;
        port_wr_i = 1'b1;
        port_wdata_i = idx;
        @(negedge clk_i);
        port_wr_i = 1'b0;
        port_data_sel_i = 1'b1;
        port_rd_i = 1'b1;
        @(negedge clk_i);
        port_rd_i = 1'b0;
        @(negedge clk_i);
        chk(port_rdata_o, exp);
    endtask : rdchk

    // Sync pins follow one cycle late; two cycles leaves margin
    task automatic sync_chk(input logic [1:0] exp);
        repeat (2) @(negedge clk_i);
        chk({6'h00, crt_horiz_sync_pin_o, crt_vert_sync_o}, {6'h00, exp});
    endtask : sync_chk

    // Counts rising edges of one derived clock over 480 cycles
    task automatic meas(input int m, input int lo, input int hi);
        int   n;
        logic p;
        n = 0;
        repeat (8) @(negedge clk_i);
        p = clks[m];
        repeat (480) begin
            @(negedge clk_i);
            if (clks[m] === 1'b1 && p === 1'b0) n++;
            p = clks[m];
        end
        cmp_count++;
        if (n < lo || n > hi) begin
            n_errors++;
            $display("MISMATCH t=%0t edge count %0d", $time, n);
        end
    endtask : meas

    // Main sequence
    initial begin
        {port_data_sel_i, port_wr_i, port_rd_i, port_wdata_i} = '0;
        {hsync_i, vsync_i, csync_i, blank_i, sleep_i, standby_i} = '0;
        {indep_refresh_i, panel_or_tv_i, seq_8dot_i, seq_dot_div2_i} = '0;
        legacy_clk_sel_i = 2'h0;
        ext_en_n = 1'b1;
        srst_i = 1'b1;
        repeat (12) @(negedge clk_i);
        srst_i = 1'b0;
        foreach (ri[k]) rdchk(ri[k], rv[k]);
        foreach (ri[k]) wr(ri[k], 8'hFF);
        foreach (ri[k]) rdchk(ri[k], rf[k]);
        chk({vclk_trim_o, mclk_trim_o, post_scaler_o, 2'b00}, 8'hFC);
        chk({7'h00, subcarrier_free_run_o}, 8'h01);
        chk({7'h00, test_data_direct_o}, 8'h01);
        chk(vid_clock_numerator_o, 8'hFF);
        chk({2'b00, vid_clock_denominator_o}, 8'h3F);
        chk(mem_clock_numerator_o, 8'hFF);
        chk({2'b00, mem_clock_denominator_o}, 8'h3F);
        // Unmapped index keeps nothing
        wr(8'h66, 8'h55);
        rdchk(8'h66, RD_UNMAPPED);
        // Sync behaviour in sleep and standby
        wr(IDX_TV_SYNC, 8'h00);
        wr(IDX_SEL_TWO, 8'h84);
        {hsync_i, vsync_i, sleep_i} = 3'b111;
        sync_chk(2'b00);
        wr(IDX_SEL_TWO, 8'h80);
        sync_chk(2'b10);
        {sleep_i, standby_i} = 2'b01;
        sync_chk(2'b01);
        {standby_i, hsync_i, csync_i} = 3'b001;
        wr(IDX_TV_SYNC, 8'h01);
        sync_chk(2'b11);
        wr(IDX_SEL_TWO, 8'h00);
        blank_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk({7'h00, tv_clock_or_blank_o}, 8'h01);
        // Character clock override only with panel or TV
        wr(IDX_SEL_ONE, 8'hD0);
        {panel_or_tv_i, seq_dot_div2_i} = 2'b11;
        repeat (2) @(negedge clk_i);
        chk({6'h00, char_8dot_o, dot_clock_div2_o}, 8'h02);
        panel_or_tv_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk({6'h00, char_8dot_o, dot_clock_div2_o}, 8'h01);
        // Clock routing, rates from the oscillator model periods
        meas(0, 29, 31);
        meas(2, 29, 31);
        ext_en_n = 1'b0;
        meas(0, 59, 61);
        meas(3, 0, 0);
        ext_en_n = 1'b1;
        meas(1, 14, 16);
        wr(IDX_TV_SYNC, 8'h02);
        meas(1, 9, 11);
        indep_refresh_i = 1'b1;
        meas(2, 9, 12);
        meas(3, 9, 12);
        wr(IDX_SEL_TWO, 8'h20);
        meas(3, 4, 6);
        // Refresh clock: memory clock when awake, 32 KHz pin in standby
        meas(4, 11, 12);
        standby_i = 1'b1;
        meas(4, 9, 10);
        standby_i = 1'b0;
        // Legacy ISO choice, then the synthesizer and its post-scaler
        wr(IDX_SEL_ONE, 8'h20);
        legacy_clk_sel_i = 2'b01;
        meas(0, 14, 16);
        wr(IDX_SEL_ONE, 8'h40);
        wr(IDX_VID_DEN, 8'h2E);
        meas(0, 13, 14);
        wr(IDX_VID_DEN, 8'h97); // half denominator, divide by 2
        meas(0, 6, 7);
        wr(IDX_VID_DEN, 8'h57);
        meas(0, 3, 4);
        complete_run();
    end

    // Runaway guard, far beyond the few thousand cycles of the sequence
    initial begin
        #(20000 * 50);
        n_errors++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire

//--- verilog/clk_ctl_pkg.sv
`default_nettype none
package clk_ctl_pkg;
    // Register indices behind the index/data port
    localparam logic [7:0] IDX_TV_SYNC = 8'h65;
    localparam logic [7:0] IDX_SEL_ONE = 8'h68;
    localparam logic [7:0] IDX_SEL_TWO = 8'h69;
    localparam logic [7:0] IDX_MEM_NUM = 8'h6A;
    localparam logic [7:0] IDX_MEM_DEN = 8'h6B;
    localparam logic [7:0] IDX_VID_NUM = 8'h6C;
    localparam logic [7:0] IDX_VID_DEN = 8'h6D;

    // Reset values; synthesizer pairs give 40.27 MHz and 28.325 MHz
    localparam logic [7:0] RST_TV_SYNC = 8'h00;
    localparam logic [7:0] RST_SEL_ONE = 8'hC0;
    localparam logic [7:0] RST_SEL_TWO = 8'h80;
    localparam logic [7:0] RST_MEM_NUM = 8'h5A;
    localparam logic [7:0] RST_MEM_DEN = 8'h20;
    localparam logic [7:0] RST_VID_NUM = 8'h5B;
    localparam logic [7:0] RST_VID_DEN = 8'h2E;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Field positions, TV and sync control
    localparam int TV_HSYNC_SEL_BIT  = 0;
    localparam int TV_SRC_BIT        = 1;
    localparam int TV_SUBCARRIER_BIT = 2;
    localparam int TV_USED_HI        = 3;
    // Field positions, clock select one
    localparam int VIDEO_CLOCK_SOURCE_FIELD_HI     = 7;
    localparam int VIDEO_CLOCK_SOURCE_FIELD_LO     = 6;
    localparam int ISO_BIT      = 5;
    localparam int CHAR8_BIT    = 4;
    localparam int VTRIM_HI     = 3;
    localparam int VTRIM_LO     = 2;
    localparam int MTRIM_HI     = 1;
    localparam int MTRIM_LO     = 0;
    // Field positions, clock select two
    localparam int TVBLANK_BIT    = 7;
    localparam int TDATA_BIT      = 6;
    localparam int LINK_HI        = 5;
    localparam int LINK_LO        = 4;
    localparam int REFRESH_BIT    = 3;
    localparam int SLEEP_SYNC_BIT = 2;
    localparam int VR_HI          = 1;
    localparam int VR_LO          = 0;
    // Field positions, denominators
    localparam int DEN_HI      = 5;
    localparam int PS_DIV2_BIT = 7;
    localparam int PS_DIV4_BIT = 6;

    // Input clock pins, in sampled order
    localparam int SRC_AUX   = 0;
    localparam int SRC_PAL   = 1;
    localparam int SRC_OSC14 = 2;
    localparam int SRC_LEG25 = 3;
    localparam int SRC_LEG28 = 4;
    localparam int SRC_LEG31 = 5;
    localparam int SRC_LEG35 = 6;
    localparam int SRC_SYN_V = 7;
    localparam int SRC_SYN_M = 8;
    localparam int SRC_VID2  = 9;
    localparam int SRC_32K   = 10;
    localparam int SRC_EXTEN = 11;
    localparam int NUM_SRC   = 12;

    // Video clock source field codes
    typedef enum logic [1:0] {
        VSRC_LEGACY = 2'b00,
        VSRC_SYNTH  = 2'b01,
        VSRC_PAL    = 2'b10,
        VSRC_OSC14  = 2'b11
    } vclk_src_t;

    // Panel refresh clock choices
    typedef enum logic [1:0] {
        VR_SECOND   = 2'b00,
        VR_MEM_HALF = 2'b01,
        VR_MEM      = 2'b10,
        VR_PROG     = 2'b11
    } vr_src_t;

    // Panel link clock choices
    typedef enum logic [1:0] {
        LK_VR      = 2'b00,
        LK_VR_INV  = 2'b01,
        LK_HALF    = 2'b10,
        LK_HALF_IN = 2'b11
    } link_src_t;

    // Guard after a clock reprogramming
    localparam int CLK_PERIOD_NS       = 50;
    localparam int SWITCH_GUARD_NS     = 200;
    localparam int SWITCH_GUARD_CYCLES =
        (SWITCH_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : clk_ctl_pkg
`default_nettype wire

//--- verilog/display_clock_select_and_synth.sv
// Overview of operation
// (R1) TV clock is aux or PAL reference input divided by four.
// (R2) Horizontal sync pin carries ordinary or composite sync by select bit.
// (R3) Subcarrier select chooses per-field alternation or free running.
// (R4) Video clock from legacy, synthesizer, 17.734, 14.318; aux when enable low.
// (R5) ISO bit raises legacy choices to 31.5 and 35.484 MHz.
// (R6) Override gives 8-dot character clock, undivided dot clock on panel/TV.
// (R7) Two trim fields adjust video and memory clock low time.
// (R8) Shared output carries blank, or quarter of programmable video clock.
// (R9) Test data source picks index or direct colour data.
// (R10) Panel link clock is refresh clock, inverse, half, or inverse half.
// (R11) Sleep refresh timed from external 32 KHz or synthesizer memory clock.
// (R12) In sleep, select bit picks DPMS suspend or off.
// (R13) Internal standby presents DPMS standby syncs automatically.
// (R14) Refresh clock select picks secondary, half memory, memory, programmable.
// (R15) Without independent refresh the panel clock is the video clock.
// (R16) Memory synthesizer uses 8-bit numerator, 6-bit denominator; bits 7:6 reserved.
// (R17) Video synthesizer uses numerator over denominator, then post-scaler.
// (R18) Post-scaler divides by 1, 2, 4, 8; 4 and 8 need source bit.
// (R19) Software halves the denominator when enabling the post-scaler.
// (R20) Reset values give 40.27 MHz memory and 28.325 MHz video clocks.
// (R21) Clock switches produce no runt pulses downstream; code guards only register writes, not pin-driven source switches.
`timescale 1ns/10ps
`default_nettype none
module display_clock_select_and_synth
    import clk_ctl_pkg::*;
#(
    parameter int GUARD_CYCLES = SWITCH_GUARD_CYCLES
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               srst_i,
    // Index/data register port
    input  wire logic               port_data_sel_i,
    input  wire logic               port_wr_i,
    input  wire logic               port_rd_i,
    input  wire logic [7:0]         port_wdata_i,
    output var  logic [7:0]         port_rdata_o,
    // Clock pins, see source order in package
    input  wire logic [NUM_SRC-1:0] clk_pins_i,
    // Same-clock timing and mode inputs
    input  wire logic               hsync_i,
    input  wire logic               vsync_i,
    input  wire logic               csync_i,
    input  wire logic               blank_i,
    input  wire logic               sleep_i,
    input  wire logic               standby_i,
    input  wire logic               indep_refresh_i,
    input  wire logic               panel_or_tv_i,
    input  wire logic [1:0]         legacy_clk_sel_i,
    input  wire logic               seq_8dot_i,
    input  wire logic               seq_dot_div2_i,
    // Derived clocks
    output var  logic               video_clock_o,
    output var  logic               tv_clock_o,
    output var  logic               tv_clock_or_blank_o,
    output var  logic               panel_refresh_clock_o,
    output var  logic               panel_link_clock_o,
    output var  logic               dram_refresh_clock_o,
    // Sync pins
    output var  logic               crt_horiz_sync_pin_o,
    output var  logic               crt_vert_sync_o,
    // Static controls toward timing logic and synthesizers
    output var  logic               char_8dot_o,
    output var  logic               dot_clock_div2_o,
    output var  logic               subcarrier_free_run_o,
    output var  logic               test_data_direct_o,
    output var  logic [1:0]         vclk_trim_o,
    output var  logic [1:0]         mclk_trim_o,
    output var  logic [7:0]         mem_clock_numerator_o,
    output var  logic [5:0]         mem_clock_denominator_o,
    output var  logic [7:0]         vid_clock_numerator_o,
    output var  logic [5:0]         vid_clock_denominator_o,
    output var  logic [1:0]         post_scaler_o
);

    if (GUARD_CYCLES < 1 || GUARD_CYCLES > 7) begin : g_guard_range
        $error("GUARD_CYCLES must lie in 1..7");
    end

    // Whole state of the block
    typedef struct packed {
        logic [NUM_SRC-1:0] s1, s2, s3, f, fp;
        logic [7:0]         idx, rdata, sel_one, sel_two;
        logic [7:0]         mem_num, vid_num, vid_den;
        logic [5:0]         mem_den;
        logic [3:0]         tv_sync;
        logic [2:0]         ps_cnt, hold;
        logic [1:0]         tv_cnt, q_cnt;
        logic               vprog, mhalf, vr_half, vclk, tv_clock, shared;
        logic               vr, link, refresh, hs, vs, char8, div2;
    } state_t;
    state_t q_q, d_d;

    // Register read decode, used only by data reads
    function automatic logic [7:0] read_reg(input logic [7:0] idx,
                                            input state_t     s);
        case (idx)
            IDX_TV_SYNC: read_reg = {4'h0, s.tv_sync};
            IDX_SEL_ONE: read_reg = s.sel_one;
            IDX_SEL_TWO: read_reg = s.sel_two;
            IDX_MEM_NUM: read_reg = s.mem_num;
            // (R16) reserved bits read zero
            IDX_MEM_DEN: read_reg = {2'b00, s.mem_den};
            IDX_VID_NUM: read_reg = s.vid_num;
            IDX_VID_DEN: read_reg = s.vid_den;
            default:     read_reg = RD_UNMAPPED;
        endcase
    endfunction : read_reg

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx >= IDX_SEL_ONE && idx <= IDX_VID_DEN)
                    || idx == IDX_TV_SYNC;
    endfunction : is_mapped

    logic [NUM_SRC-1:0] rise;
    logic [1:0]         ps_code;
    logic               data_wr, vp_next, vr_next, vr_rise, gate;

    // Next state
    always_comb begin
        d_d = q_q;
        data_wr = port_wr_i && port_data_sel_i && is_mapped(q_q.idx);

        // Pins pass three flops; a change counts when the last two agree
        d_d.s1 = clk_pins_i;
        d_d.s2 = q_q.s1;
        d_d.s3 = q_q.s2;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (q_q.s2[i] == q_q.s3[i]) begin
                d_d.f[i] = q_q.s3[i];
            end
        end
        d_d.fp = q_q.f;
        rise = q_q.f & ~q_q.fp;

        // Index/data port; unmapped indices ignore writes
        if (port_wr_i && !port_data_sel_i) begin
            d_d.idx = port_wdata_i;
        end
        if (port_rd_i) begin
            d_d.rdata = port_data_sel_i ? read_reg(q_q.idx, q_q) : q_q.idx;
        end
        if (data_wr) begin
            case (q_q.idx)
                IDX_TV_SYNC: d_d.tv_sync = port_wdata_i[TV_USED_HI:0];
                IDX_SEL_ONE: d_d.sel_one = port_wdata_i;
                IDX_SEL_TWO: d_d.sel_two = port_wdata_i;
                IDX_MEM_NUM: d_d.mem_num = port_wdata_i;
                IDX_MEM_DEN: d_d.mem_den = port_wdata_i[DEN_HI:0];
                IDX_VID_NUM: d_d.vid_num = port_wdata_i;
                IDX_VID_DEN: d_d.vid_den = port_wdata_i;
                default:     d_d.idx = q_q.idx;
            endcase
        end

        // (R21) any reprogramming parks every derived clock low a while
        if (data_wr) begin
            d_d.hold = 3'(GUARD_CYCLES);
        end else if (q_q.hold != 3'h0) begin
            d_d.hold = q_q.hold - 3'h1;
        end
        gate = (d_d.hold == 3'h0);

        // (R1) TV clock from aux or PAL reference, divided by four
        if (q_q.tv_sync[TV_SRC_BIT] ? rise[SRC_PAL] : rise[SRC_AUX]) begin
            d_d.tv_cnt = q_q.tv_cnt + 2'h1;
        end

        // (R18) post-scaler; 4 and 8 only with a source bit set
        ps_code = {q_q.vid_den[PS_DIV4_BIT]
                   && (q_q.sel_one[VIDEO_CLOCK_SOURCE_FIELD_HI] || q_q.sel_one[VIDEO_CLOCK_SOURCE_FIELD_LO]),
                   q_q.vid_den[PS_DIV2_BIT]};
        if (rise[SRC_SYN_V]) begin
            d_d.ps_cnt = q_q.ps_cnt + 3'h1;
        end
        // (R17) synthesized clock then post-scaled
        case (ps_code)
            2'b00:   vp_next = q_q.f[SRC_SYN_V];
            2'b01:   vp_next = q_q.ps_cnt[0];
            2'b10:   vp_next = q_q.ps_cnt[1];
            default: vp_next = q_q.ps_cnt[2];
        endcase
        d_d.vprog = vp_next;
        // (R8) quarter of the programmable clock
        if (vp_next && !q_q.vprog) begin
            d_d.q_cnt = q_q.q_cnt + 2'h1;
        end
        if (rise[SRC_SYN_M]) begin
            d_d.mhalf = ~q_q.mhalf;
        end

        // (R4) video clock source; enable pin low forces aux input
        d_d.vclk = q_q.f[SRC_AUX];
        if (q_q.f[SRC_EXTEN]) begin
            case (vclk_src_t'(q_q.sel_one[VIDEO_CLOCK_SOURCE_FIELD_HI:VIDEO_CLOCK_SOURCE_FIELD_LO]))
                VSRC_LEGACY: begin
                    // (R5) ISO raises the legacy choices
                    case (legacy_clk_sel_i)
                        2'b00:   d_d.vclk = q_q.sel_one[ISO_BIT]
                                     ? q_q.f[SRC_LEG31] : q_q.f[SRC_LEG25];
                        2'b01:   d_d.vclk = q_q.sel_one[ISO_BIT]
                                     ? q_q.f[SRC_LEG35] : q_q.f[SRC_LEG28];
                        default: d_d.vclk = q_q.f[SRC_AUX];
                    endcase
                end
                VSRC_SYNTH:  d_d.vclk = vp_next;
                VSRC_PAL:    d_d.vclk = q_q.f[SRC_PAL];
                VSRC_OSC14:  d_d.vclk = q_q.f[SRC_OSC14];
                default:     d_d.vclk = q_q.f[SRC_AUX];
            endcase
        end

        // (R15) without independent refresh the video clock is used
        if (!indep_refresh_i) begin
            vr_next = d_d.vclk;
        end else begin
            // (R14) refresh clock choice
            case (vr_src_t'(q_q.sel_two[VR_HI:VR_LO]))
                VR_SECOND:   vr_next = q_q.f[SRC_VID2];
                VR_MEM_HALF: vr_next = q_q.mhalf;
                VR_MEM:      vr_next = q_q.f[SRC_SYN_M];
                default:     vr_next = vp_next;
            endcase
        end
        vr_rise = vr_next && !q_q.vr;
        if (vr_rise) begin
            d_d.vr_half = ~q_q.vr_half;
        end

        // (R10) link clock, only while the enable pin is high
        case (link_src_t'(q_q.sel_two[LINK_HI:LINK_LO]))
            LK_VR:     d_d.link = vr_next;
            LK_VR_INV: d_d.link = ~vr_next;
            LK_HALF:   d_d.link = d_d.vr_half;
            default:   d_d.link = ~d_d.vr_half;
        endcase
        d_d.link = d_d.link && q_q.f[SRC_EXTEN] && gate;

        // (R11) low-power refresh from 32 KHz pin or memory clock
        d_d.refresh = ((sleep_i || standby_i)
                       && !q_q.sel_two[REFRESH_BIT])
                      ? q_q.f[SRC_32K] : q_q.f[SRC_SYN_M];

        // (R2) ordinary or composite sync on the horizontal pin
        d_d.hs = q_q.tv_sync[TV_HSYNC_SEL_BIT] ? csync_i : hsync_i;
        d_d.vs = vsync_i;
        if (sleep_i) begin
            // (R12) suspend stops vertical, off stops both
            d_d.vs = 1'b0;
            if (q_q.sel_two[SLEEP_SYNC_BIT]) begin
                d_d.hs = 1'b0;
            end
        end else if (standby_i) begin
            // (R13) standby stops horizontal only
            d_d.hs = 1'b0;
        end

        // (R6) override ignores the sequencer's dot and 8-dot bits
        if (q_q.sel_one[CHAR8_BIT] && panel_or_tv_i) begin
            d_d.char8 = 1'b1;
            d_d.div2  = 1'b0;
        end else begin
            d_d.char8 = seq_8dot_i;
            d_d.div2  = seq_dot_div2_i;
        end

        // Clock outputs held low through the guard to avoid runts
        d_d.vclk    = d_d.vclk && gate;
        d_d.vr      = vr_next && gate;
        d_d.tv_clock   = d_d.tv_cnt[1] && gate;
        // (R8) blank or quarter programmable clock on the shared pin
        d_d.shared  = q_q.sel_two[TVBLANK_BIT]
                      ? (d_d.q_cnt[1] && gate) : blank_i;
        d_d.refresh = d_d.refresh && gate;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q_q         <= '0;
            // (R20) default synthesizer settings
            q_q.tv_sync <= RST_TV_SYNC[TV_USED_HI:0];
            q_q.sel_one <= RST_SEL_ONE;
            q_q.sel_two <= RST_SEL_TWO;
            q_q.mem_num <= RST_MEM_NUM;
            q_q.mem_den <= RST_MEM_DEN[DEN_HI:0];
            q_q.vid_num <= RST_VID_NUM;
            q_q.vid_den <= RST_VID_DEN;
        end else begin
            q_q <= d_d;
        end
    end

    // Outputs straight from the state register
    assign port_rdata_o            = q_q.rdata;
    assign video_clock_o           = q_q.vclk;
    assign tv_clock_o              = q_q.tv_clock;
    assign tv_clock_or_blank_o     = q_q.shared;
    assign panel_refresh_clock_o   = q_q.vr;
    assign panel_link_clock_o      = q_q.link;
    assign dram_refresh_clock_o    = q_q.refresh;
    assign crt_horiz_sync_pin_o    = q_q.hs;
    assign crt_vert_sync_o         = q_q.vs;
    assign char_8dot_o             = q_q.char8;
    assign dot_clock_div2_o        = q_q.div2;
    // (R3) subcarrier mode and (R9) test data source are static levels
    assign subcarrier_free_run_o   = q_q.tv_sync[TV_SUBCARRIER_BIT];
    assign test_data_direct_o      = q_q.sel_two[TDATA_BIT];
    // (R7) trim codes go to the delay cells
    assign vclk_trim_o             = q_q.sel_one[VTRIM_HI:VTRIM_LO];
    assign mclk_trim_o             = q_q.sel_one[MTRIM_HI:MTRIM_LO];
    assign mem_clock_numerator_o   = q_q.mem_num;
    assign mem_clock_denominator_o = q_q.mem_den;
    assign vid_clock_numerator_o   = q_q.vid_num;
    assign vid_clock_denominator_o = q_q.vid_den[DEN_HI:0];
    assign post_scaler_o           = q_q.vid_den[PS_DIV2_BIT:PS_DIV4_BIT];

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    a_hsync_route: assert property ( // (R2)
        !sleep_i && !standby_i |=> crt_horiz_sync_pin_o ==
            ($past(q_q.tv_sync[TV_HSYNC_SEL_BIT]) ? $past(csync_i)
                                                  : $past(hsync_i)))
        else $error("horizontal sync pin carries wrong sync");
    a_dpms_off: assert property ( // (R12)
        sleep_i && q_q.sel_two[SLEEP_SYNC_BIT]
        |=> !crt_horiz_sync_pin_o && !crt_vert_sync_o)
        else $error("sync pulses in DPMS off");
    a_dpms_suspend: assert property ( // (R12)
        sleep_i && !q_q.sel_two[SLEEP_SYNC_BIT]
        |=> !crt_vert_sync_o && crt_horiz_sync_pin_o == $past(q_q.tv_sync[0]
            ? csync_i : hsync_i))
        else $error("suspend sync state wrong");
    a_standby_sync: assert property ( // (R13)
        standby_i && !sleep_i |=> !crt_horiz_sync_pin_o
            && crt_vert_sync_o == $past(vsync_i))
        else $error("standby sync state wrong");
    a_char_override: assert property ( // (R6)
        q_q.sel_one[CHAR8_BIT] && panel_or_tv_i
        |=> char_8dot_o && !dot_clock_div2_o)
        else $error("character clock override ignored");
    a_guard_hold: assert property ( // (R21)
        data_wr |=> (!video_clock_o && !panel_refresh_clock_o)[*4])
        else $error("clock moved during switch guard");
    a_link_gate: assert property ( // (R10)
        !q_q.f[SRC_EXTEN] |=> !panel_link_clock_o)
        else $error("link clock runs with enable pin low");
    a_den_reserved: assert property ( // (R16)
        port_rd_i && port_data_sel_i && q_q.idx == IDX_MEM_DEN
        |=> port_rdata_o[7:6] == 2'b00)
        else $error("reserved denominator bits read nonzero");
    a_reset_defaults: assert property ( // (R20)
        $fell(srst_i) |-> mem_clock_numerator_o == RST_MEM_NUM
            && vid_clock_numerator_o == RST_VID_NUM
            && post_scaler_o == 2'b00)
        else $error("synthesizer defaults wrong after reset");

    c_sleep_off: cover property (sleep_i && q_q.sel_two[SLEEP_SYNC_BIT]);
    c_reprogram: cover property (data_wr ##5 video_clock_o);
    c_tv_shared: cover property (q_q.sel_two[TVBLANK_BIT]
                                 && tv_clock_or_blank_o);

endmodule : display_clock_select_and_synth
`default_nettype wire
